// ==== hpd_ctrl_model.sv ====
// External controller model: pull-up pins and pulse/direction edge bookkeeping.
`timescale 1ns/1ps
module hpd_ctrl_model (
    input  wire logic mclk,        // System clock.
    input  wire logic sys_rst,     // Synchronous reset, active high.
    input  wire logic pulse_out,   // Pulse pin drive value.
    input  wire logic pulse_oe,    // Pulse pin enable, high pulls low.
    input  wire logic dir_out,     // Direction pin drive value.
    input  wire logic dir_oe,      // Direction pin enable, high pulls low.
    output logic      pulse_pin,   // Pulse pin level as the controller sees it.
    output logic      dir_pin,     // Direction pin level as the controller sees it.
    output int        pulse_edges, // Pulse pin edges seen since reset.
    output int        skew_count   // Direction moves with no pulse edge.
);
    // =====================================================================
    // Pin resolution
    // =====================================================================
    logic pulse_last; // Pulse pin level at the previous edge.
    logic dir_last;   // Direction pin level at the previous edge.

    assign pulse_pin = pulse_oe ? pulse_out : 1'b1;
    assign dir_pin   = dir_oe ? dir_out : 1'b1;

    // Counts edges; a direction move without a pulse move reveals skew.
    always @(posedge mclk) begin
        if (sys_rst) begin
            pulse_edges <= 0;
            skew_count  <= 0;
        end else begin
            if (pulse_pin !== pulse_last) begin
                pulse_edges <= pulse_edges + 1;
            end
            if (dir_pin !== dir_last && pulse_pin === pulse_last) begin
                skew_count <= skew_count + 1;
            end
        end
        pulse_last <= pulse_pin;
        dir_last   <= dir_pin;
    end
endmodule

// ==== hpd_latch.sv ====
// Hysteresis latch fed by an operate and a release comparator.
`timescale 1ns/1ps
module hpd_latch (
    input  wire logic mclk,         // System clock.
    input  wire logic sys_rst,      // Synchronous reset, active high.
    input  wire logic sample,       // One-cycle strobe to evaluate.
    input  wire logic above_op,     // Synchronised: field above operate point.
    input  wire logic below_rel,    // Synchronised: field below release point.
    output logic      state         // Latch state, low when operated.
);

    // =====================================================================
    // Latch
    // =====================================================================

    // Next latch value.
    logic next_state;

    // Operate drives low, release drives high, between them it holds.
    always_comb begin
        next_state = state;
        if (sample) begin
            if (above_op) begin
                next_state = 1'h0;
            end else if (below_rel) begin
                next_state = 1'h1;
            end
        end
    end

    // Register the latch.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= hpd_pkg::LATCH_RST;
        end else begin
            state <= next_state;
        end
    end

    // Latch goes low after an operate sample.
    latch_operate_a: assert property (@(posedge mclk) disable iff (sys_rst)  // RQ1 RQ2
        sample && above_op |=> !state) else $error("latch did not operate");
    // Latch holds without a sample.
    latch_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)  // RQ1 RQ2
        !sample |=> $stable(state)) else $error("latch changed unsampled");

endmodule

// ==== hpd_pkg.sv ====
// Package of constants shared by the Hall pulse and direction logic.
//
// Summary of operation
// [RQ1] Vertical latch: low above operate, high below release.
// [RQ2] Horizontal latch: low above operate, high below release.
// [RQ3] Pulse output equals vertical XOR horizontal latch.
// [RQ4] Direction updates only on pulse output edges.
// [RQ5] Direction and pulse change in same cycle.
// [RQ6] Direction undefined only until first pulse.
// [RQ7] Sensors driven and sampled only in window.
// [RQ8] Both outputs are open-drain drivers.
// [RQ9] Vertical leading horizontal gives direction high.
package hpd_pkg;

    // =====================================================================
    // Timing
    // =====================================================================

    // Clock period in picoseconds, 125 MHz.
    localparam int unsigned CLK_PERIOD_PS = 8000;
    // Sensing period, typical figure in nanoseconds.
    localparam int unsigned DRIVE_PERIOD_NS = 48800;
    // Drive window, typical figure in nanoseconds.
    localparam int unsigned DRIVE_WINDOW_NS = 24400;
    // Period in cycles, a longest time, rounded down.
    localparam int unsigned DRIVE_PERIOD_CYC = (DRIVE_PERIOD_NS * 1000) / CLK_PERIOD_PS;
    // Window in cycles, a least time, rounded up.
    localparam int unsigned DRIVE_WINDOW_CYC =
        (DRIVE_WINDOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Width of the period counter.
    localparam int unsigned CNT_W = 13;

    // =====================================================================
    // Reset values
    // =====================================================================

    // Latches start released, which reads high.
    localparam logic LATCH_RST = 1'h1;
    // Direction pin stays released while undefined.
    localparam logic DIR_RST = 1'h1;

    // Sensing sequencer states; each step flips one bit but SAMPLE to IDLE.
    typedef enum logic [1:0] {
        HPD_IDLE   = 2'h0,
        HPD_DRIVE  = 2'h1,
        HPD_SAMPLE = 2'h3
    } hpd_state_type;

endpackage

// ==== hpd_top.sv ====
// Hall pulse and direction logic: sequencer, latches and open-drain outputs.
`timescale 1ns/1ps
module hpd_top (
    input  wire logic mclk,             // System clock, 125 MHz.
    input  wire logic sys_rst,          // Synchronous reset, active high.
    input  wire logic vert_above_op,    // Comparator: vertical above operate.
    input  wire logic vert_below_rel,   // Comparator: vertical below release.
    input  wire logic horiz_above_op,   // Comparator: horizontal above operate.
    input  wire logic horiz_below_rel,  // Comparator: horizontal below release.
    output logic      sensor_drive,     // High while the Hall sensors are energised.
    output logic      pulse_out,        // Pulse pin output value, always low.
    output logic      pulse_oe,         // Pulse pin enable, high pulls low.
    output logic      dir_out,          // Direction pin output value, always low.
    output logic      dir_oe,           // Direction pin enable, high pulls low.
    output logic      dir_valid         // High once direction is defined.
);

    // =====================================================================
    // Input synchronisers
    // =====================================================================

    // Comparator inputs cross from the analog side, so two flops each.
    logic [3:0] cmp_meta;   // First stage, read only by the second.
    logic [3:0] cmp_sync;   // Second stage, safe to use.

    // Both stages shift every cycle.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmp_meta <= 4'h0;
            cmp_sync <= 4'h0;
        end else begin
            cmp_meta <= {horiz_below_rel, horiz_above_op, vert_below_rel, vert_above_op};
            cmp_sync <= cmp_meta;
        end
    end

    // =====================================================================
    // Sensing sequencer
    // =====================================================================

    hpd_pkg::hpd_state_type state;       // Current sequencer state.
    hpd_pkg::hpd_state_type next_state;  // Next sequencer state.
    logic [hpd_pkg::CNT_W-1:0] cnt;      // Cycle within the period.
    logic [hpd_pkg::CNT_W-1:0] next_cnt; // Next cycle count.
    logic                      sample;   // Evaluate strobe, one cycle.

    localparam logic [hpd_pkg::CNT_W-1:0] LAST_CYC =
        hpd_pkg::CNT_W'(hpd_pkg::DRIVE_PERIOD_CYC - 1);
    localparam logic [hpd_pkg::CNT_W-1:0] WIN_END =
        hpd_pkg::CNT_W'(hpd_pkg::DRIVE_WINDOW_CYC - 1);

    // [RQ7] drive window timing
    // The window opens at count zero; comparators are read at its last
    // cycle, once two synchroniser cycles of settling have passed.
    always_comb begin
        next_cnt   = (cnt == LAST_CYC) ? '0 : cnt + 1'b1;
        next_state = state;
        sample     = 1'b0;
        case (state)
            hpd_pkg::HPD_IDLE: begin
                if (cnt == LAST_CYC) begin
                    next_state = hpd_pkg::HPD_DRIVE;
                end
            end
            hpd_pkg::HPD_DRIVE: begin
                if (cnt == WIN_END - 1'b1) begin
                    next_state = hpd_pkg::HPD_SAMPLE;
                end
            end
            hpd_pkg::HPD_SAMPLE: begin
                sample     = 1'b1;
                next_state = hpd_pkg::HPD_IDLE;
            end
            default: begin
                next_state = hpd_pkg::HPD_IDLE;
            end
        endcase
    end

    // Register sequencer state; after reset the first window starts at once.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= hpd_pkg::HPD_DRIVE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // [RQ7] sensor energise gate
    // Drive stands through the whole window, including the sample cycle.
    assign sensor_drive = (state != hpd_pkg::HPD_IDLE);

    // =====================================================================
    // Hysteresis latches
    // =====================================================================

    logic vert_latch;   // Vertical field latch.
    logic horiz_latch;  // Horizontal field latch.

    // [RQ1] vertical hysteresis latch
    hpd_latch u_vert (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .sample    (sample),
        .above_op  (cmp_sync[0]),
        .below_rel (cmp_sync[1]),
        .state     (vert_latch)
    );

    // [RQ2] horizontal hysteresis latch
    hpd_latch u_horiz (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .sample    (sample),
        .above_op  (cmp_sync[2]),
        .below_rel (cmp_sync[3]),
        .state     (horiz_latch)
    );

    // =====================================================================
    // Pulse and direction
    // =====================================================================

    logic pulse;        // Registered pulse level.
    logic dir;          // Registered direction level.
    logic vert_prev;    // Vertical latch at the previous edge.
    logic next_pulse;   // Next pulse level.
    logic next_dir;     // Next direction level.
    logic next_valid;   // Next direction-defined flag.
    logic next_vprev;   // Next stored vertical latch.
    logic pulse_edge;   // Pulse level about to change.

    // [RQ3] pulse equals latch XOR
    // [RQ4] direction only at pulse edges
    // In quadrature exactly one latch moves per edge. A vertical move that
    // raises the pulse, or a horizontal move that lowers it, means the
    // vertical latch leads, so direction goes high; the mirror cases go low.
    // Judging the move alone would flip direction on every edge of a steady
    // rotation, so the new pulse level has to take part.
    // Both outputs are registered from the same latches, so the pins cannot
    // skew against each other.
    always_comb begin
        next_pulse = vert_latch ^ horiz_latch;
        pulse_edge = (next_pulse != pulse);
        next_dir   = dir;
        next_valid = dir_valid;
        next_vprev = vert_prev;
        if (pulse_edge) begin
            // [RQ9] quadrature order decides direction
            next_dir   = ((vert_latch != vert_prev) == next_pulse);
            next_vprev = vert_latch;
            // [RQ6] defined after first pulse
            // The first edge only captures history; the second ends the pulse.
            next_valid = dir_valid | pulse;
        end
    end

    // [RQ5] same-cycle pulse and direction
    // Register the outputs together. Undefined direction is shown as a
    // released pin, since the first edge has no history to judge from.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pulse     <= 1'h0;
            dir       <= hpd_pkg::DIR_RST;
            dir_valid <= 1'h0;
            vert_prev <= hpd_pkg::LATCH_RST;
        end else begin
            pulse     <= next_pulse;
            dir       <= next_valid ? next_dir : hpd_pkg::DIR_RST;
            dir_valid <= next_valid;
            vert_prev <= next_vprev;
        end
    end

    // [RQ8] open-drain pin drivers
    // Drive low for a logic low, release for a high.
    assign pulse_out = 1'b0;
    assign pulse_oe  = ~pulse;
    assign dir_out   = 1'b0;
    assign dir_oe    = ~dir;

    // =====================================================================
    // Checks
    // =====================================================================

    // Helper for the window-length check: drive cycles seen in this window.
    logic [hpd_pkg::CNT_W-1:0] drive_run;       // Drive cycles counted so far.
    logic [hpd_pkg::CNT_W-1:0] next_drive_run;  // Next drive cycle count.

    // Count while the sensors are driven, clear in the idle gap.
    always_comb begin
        next_drive_run = '0;
        if (sensor_drive) begin
            next_drive_run = drive_run + 1'b1;
        end
    end

    // Register the helper count.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            drive_run <= '0;
        end else begin
            drive_run <= next_drive_run;
        end
    end

    pulse_xor_a: assert property (@(posedge mclk) disable iff (sys_rst)   // RQ3
        pulse == $past(vert_latch ^ horiz_latch)) else $error("pulse not latch xor");
    dir_edge_a: assert property (@(posedge mclk) disable iff (sys_rst)    // RQ4
        $changed(dir) |-> $changed(pulse)) else $error("direction moved off edge");
    dir_order_a: assert property (@(posedge mclk) disable iff (sys_rst)   // RQ9
        $changed(pulse) && dir_valid && $past(vert_latch == vert_prev) |-> dir != pulse)
        else $error("horizontal move not decoded");
    dir_vlead_a: assert property (@(posedge mclk) disable iff (sys_rst)   // RQ9
        $changed(pulse) && dir_valid && $past(vert_latch != vert_prev) |-> dir == pulse)
        else $error("vertical move not decoded");
    valid_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst) // RQ6
        dir_valid |=> dir_valid) else $error("direction became undefined");
    valid_late_a: assert property (@(posedge mclk) disable iff (sys_rst)  // RQ6
        $rose(dir_valid) |-> $fell(pulse)) else $error("defined before pulse end");
    drive_win_a: assert property (@(posedge mclk) disable iff (sys_rst)   // RQ7
        sample |-> sensor_drive && $past(sensor_drive, 2)) else $error("sample off window");
    drive_len_a: assert property (@(posedge mclk) disable iff (sys_rst)   // RQ7
        $rose(sensor_drive) |-> sensor_drive [*8]) else $error("window too short");
    drive_span_a: assert property (@(posedge mclk) disable iff (sys_rst)  // RQ7
        $fell(sensor_drive) |-> drive_run == WIN_END + 1'b1) else $error("window length wrong");
    od_pins_a: assert property (@(posedge mclk) disable iff (sys_rst)     // RQ8
        !pulse_out && !dir_out && (pulse_oe == !pulse) && (dir_oe == !dir))
        else $error("pin not open drain");

    pulse_rise_c: cover property (@(posedge mclk) disable iff (sys_rst) $rose(pulse));
    dir_valid_c: cover property (@(posedge mclk) disable iff (sys_rst) $rose(dir_valid));
    dir_flip_c: cover property (@(posedge mclk) disable iff (sys_rst)
        dir_valid && $changed(dir));

endmodule

// ==== testbench.sv ====
// Self-checking testbench of the Hall pulse and direction logic.
`timescale 1ns/1ps
`define CHK(A, B) begin checks_done++; if ((A) !== (B)) begin num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, A, B); end end
module testbench;
    // =====================================================================
    // Signals
    // =====================================================================
    logic mclk = 1'b0;  // Clock, 125 MHz.
    logic sys_rst = 1'b1; // Reset, held at start.
    logic va = 1'b0, vb = 1'b0, ha = 1'b0, hb = 1'b0; // Comparator inputs.
    logic sensor_drive, pulse_out, pulse_oe, dir_out, dir_oe, dir_valid;
    logic pulse_pin, dir_pin;           // Resolved pin levels.
    int   pulse_edges, skew_count;      // Controller bookkeeping.
    int   num_errors = 0;               // Mismatches.
    int   checks_done = 0;              // Comparisons.
    int   hi_run = 0, lo_run = 0, hi_len = 0, lo_len = 0; // Window timing.
    int   mv = 1, mh = 1, mp = 0, mdir = 1, edges = 0, mvp = 1; // Behavioural model.
    logic [31:0] rnd = 32'hcc02;        // Xorshift state.
    logic [3:0] table_c [9] = '{4'h8, 4'h2, 4'h4, 4'h1, 4'h0, 4'h2, 4'h8, 4'h1, 4'hc};

    always #4 mclk = ~mclk;

    hpd_top hpd_top_inst (.mclk(mclk), .sys_rst(sys_rst), .vert_above_op(va),
        .vert_below_rel(vb), .horiz_above_op(ha), .horiz_below_rel(hb),
        .sensor_drive(sensor_drive), .pulse_out(pulse_out), .pulse_oe(pulse_oe),
        .dir_out(dir_out), .dir_oe(dir_oe), .dir_valid(dir_valid));
    hpd_ctrl_model hpd_ctrl_model_inst (.mclk(mclk), .sys_rst(sys_rst),
        .pulse_out(pulse_out), .pulse_oe(pulse_oe), .dir_out(dir_out), .dir_oe(dir_oe),
        .pulse_pin(pulse_pin), .dir_pin(dir_pin), .pulse_edges(pulse_edges),
        .skew_count(skew_count));

    // Measures the length of each drive window and each idle gap.
    always @(posedge mclk) begin
        if (sys_rst) begin
            hi_run = 0;
            lo_run = 0;
        end else if (sensor_drive === 1'b1) begin
            if (lo_run > 0) lo_len = lo_run;
            lo_run = 0;
            hi_run++;
        end else begin
            if (hi_run > 0) hi_len = hi_run;
            hi_run = 0;
            lo_run++;
        end
    end

    // =====================================================================
    // Tasks
    // =====================================================================
    // Xorshift step for the random glitches and random sample values.
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        t = t ^ (t << 5);
        return t;
    endfunction

    // Predicts latches, pulse and direction after one sample of c.
    task automatic model(input logic [3:0] c);
        int np;
        // operate wins, else release, else hold
        if (c[3]) mv = 0; else if (c[2]) mv = 1;
        if (c[1]) mh = 0; else if (c[0]) mh = 1;
        np = mv ^ mh;
        if (np != mp) begin
            edges++;
            // forward: vertical moved since last edge and pulse rose, or not and fell
            if (edges >= 2) mdir = ((mv != mvp) == (np == 1)) ? 1 : 0;
            mvp = mv;
        end
        mp = np;
    endtask

    // Waits for the end of the next drive window, then checks outputs.
    task automatic check(input int k);
        int n;
        n = 0;
        while (sensor_drive !== 1'b1 && n < 7000) begin @(negedge mclk); n++; end
        while (sensor_drive !== 1'b0 && n < 14000) begin @(negedge mclk); n++; end
        repeat (2) @(negedge mclk);
        `CHK(pulse_pin, 1'(mp))
        `CHK(dir_valid, 1'(edges >= 2))
        if (edges >= 2) `CHK(dir_pin, 1'(mdir))
        else `CHK(dir_pin, 1'b1)
        `CHK(pulse_edges, edges)
        `CHK(skew_count, 0)
        `CHK({pulse_out, dir_out}, 2'h0)
        if (k > 0) `CHK(hi_len, int'(hpd_pkg::DRIVE_WINDOW_CYC))
        if (k > 0) `CHK(hi_len + lo_len, int'(hpd_pkg::DRIVE_PERIOD_CYC))
    endtask

    // Glitches the inputs outside the window, then applies c for the next sample.
    task automatic step(input logic [3:0] c, input int k);
        rnd = xs(rnd);
        {va, vb, ha, hb} = rnd[3:0];
        repeat (100) @(negedge mclk);
        {va, vb, ha, hb} = c;
        model(c);
        check(k);
    endtask

    task automatic end_of_test();
        $display("Checks %0d, errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // =====================================================================
    // Main sequence: forward and reverse quadrature, hold, then random.
    // =====================================================================
    initial begin
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        check(0);
        for (int i = 0; i < 9; i++) step(table_c[i], i + 1);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            step(rnd[7:4], 1);
        end
        end_of_test();
    end

    // Cuts a hang short; the full run needs about 82400 cycles.
    initial begin
        #(8 * 98000);
        num_errors++;
        end_of_test();
    end
endmodule
